// File: msrb_pkg.sv
package msrb_pkg;
    localparam logic [31:0] MSRB_IDX_CYCLE   = 32'h0000_0010;
    localparam logic [31:0] MSRB_IDX_SERIAL  = 32'h0000_0119;
    localparam logic [31:0] MSRB_IDX_FC_SEL  = 32'h0000_0174;
    localparam logic [31:0] MSRB_IDX_FC_ESP  = 32'h0000_0175;
    localparam logic [31:0] MSRB_IDX_FC_EIP  = 32'h0000_0176;
    localparam logic [31:0] MSRB_IDX_SIG     = 32'h8086_0000;
    localparam logic [31:0] MSRB_IDX_VND1    = 32'h8086_0001;
    localparam logic [31:0] MSRB_IDX_VND2    = 32'h8086_0002;
    localparam logic [31:0] MSRB_IDX_VND3    = 32'h8086_0003;
    localparam logic [31:0] MSRB_IDX_MASK    = 32'h8086_0004;
    localparam logic [31:0] MSRB_IDX_PERF    = 32'h8086_8010;

    localparam int          MSRB_SERIAL_BIT  = 21;
    localparam int          MSRB_CMPXCHG_BIT = 8;
    localparam int          MSRB_FC_FLAG_BIT = 11;
    localparam logic [31:0] MSRB_PERF_MAX    = 32'h0000_0064;
    localparam logic [63:0] MSRB_SIG_RSVD    = 64'hFFFF_FFFF_FFFF_C000;
    localparam logic [63:0] MSRB_SIG_RESET   = 64'h0000_0000_0000_0000;
    localparam logic [31:0] MSRB_MASK_RESET  = 32'hFFFF_FFFF;
    localparam logic [31:0] MSRB_VND_RESET   = 32'h0000_0000;

    typedef enum logic [1:0] {
        MSRB_OP_READ  = 2'b00,
        MSRB_OP_WRITE = 2'b01,
        MSRB_OP_TSC   = 2'b10
    } msrb_op_e;

    typedef struct packed {
        logic        valid;
        msrb_op_e    op;
        logic [1:0]  cpl;
        logic        tsd;
        logic [31:0] index;
        logic [31:0] edx;
        logic [31:0] eax;
    } msrb_req_s;

    typedef struct packed {
        logic        done;
        logic        fault;
        logic        serialize;
        logic [31:0] edx;
        logic [31:0] eax;
    } msrb_rsp_s;

    typedef struct packed {
        logic [31:0] vendor_ebx;
        logic [31:0] vendor_edx;
        logic [31:0] vendor_ecx;
        logic [31:0] signature_eax;
        logic [31:0] feature_edx;
    } msrb_id_s;

    typedef struct packed {
        logic [63:0] cycle_counter;
        logic        serial_disable;
        logic        strap_taken;
        logic [31:0] fc_sel;
        logic [31:0] fc_esp;
        logic [31:0] fc_eip;
        logic [13:0] sig;
        logic [31:0] vnd1;
        logic [31:0] vnd2;
        logic [31:0] vnd3;
        logic [31:0] mask;
        logic [31:0] perf_hi;
        logic [31:0] perf_lo;
        msrb_rsp_s   rsp;
        msrb_id_s    id;
    } msrb_state_s;
endpackage

// File: msrb_bank.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Registers 64 bits; unimplemented bits read zero
// - Writing one into reserved bit faults
// - Unknown register index faults on access
// - Index in ECX, data in EDX:EAX
// - Top privilege only; writes serialize
// - Cycle counter increments every core clock
// - Timestamp read faults only when disabled
// - Serial disable bit sticky until reset
// - Serial disable reset value from strap
// - Selector low 16, scratch 31-16, upper zero
// - Stack pointer low 32, upper zero
// - Instruction pointer low 32, upper zero
// - Fast call presence via feature flag
// - Signature override feeds identification EAX
// - Vendor words feed EBX, EDX, ECX
// - Zero mask bits force feature flags zero
// - Compare-exchange mask bit defaults unmasked
// - Performance window bounds checked on write
module msrb_bank (
    input  wire logic               clk_in,
    input  wire logic               resetn_in,
    input  wire logic               serial_disable_strap_in,
    input  wire logic [31:0]        base_features_in,
    input  msrb_pkg::msrb_req_s     req_in,
    output msrb_pkg::msrb_rsp_s     rsp_out,
    output msrb_pkg::msrb_id_s      id_out,
    output logic                    serial_disabled_out,
    output logic [63:0]             cycle_count_out
);
    import msrb_pkg::*;

    msrb_state_s state_reg;
    msrb_state_s state_next;
    logic        strap_meta_reg;
    logic        strap_sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // Strap passes two flops before use
    // No reset here, so the settled strap is ready at the first edge after release
    always_ff @(posedge clk_in) begin
        strap_meta_reg <= serial_disable_strap_in;
        strap_sync_reg <= strap_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic index_known(input logic [31:0] idx);
        index_known = (idx == MSRB_IDX_CYCLE) || (idx == MSRB_IDX_SERIAL) ||
                      (idx == MSRB_IDX_FC_SEL) || (idx == MSRB_IDX_FC_ESP) ||
                      (idx == MSRB_IDX_FC_EIP) || (idx == MSRB_IDX_SIG) ||
                      (idx == MSRB_IDX_VND1) || (idx == MSRB_IDX_VND2) ||
                      (idx == MSRB_IDX_VND3) || (idx == MSRB_IDX_MASK) ||
                      (idx == MSRB_IDX_PERF);
    endfunction

    // Bits that software may never set, per register
    function automatic logic [63:0] reserved_bits(input logic [31:0] idx);
        logic [63:0] r;
        r = 64'h0000_0000_0000_0000;
        if (idx == MSRB_IDX_SERIAL) begin
            r = ~(64'h0000_0000_0000_0001 << MSRB_SERIAL_BIT);
        end else if (idx == MSRB_IDX_SIG) begin
            r = MSRB_SIG_RSVD;
        end
        // Fast call upper halves are ignored, not reserved
        reserved_bits = r;
    endfunction

    function automatic logic [63:0] read_value(input msrb_state_s s, input logic [31:0] idx);
        logic [63:0] v;
        v = 64'h0000_0000_0000_0000;
        unique case (idx)
            MSRB_IDX_CYCLE:  v = s.cycle_counter;
            MSRB_IDX_SERIAL: v = {42'h0, s.serial_disable, 21'h0};
            MSRB_IDX_FC_SEL: v = {32'h0, s.fc_sel};
            MSRB_IDX_FC_ESP: v = {32'h0, s.fc_esp};
            MSRB_IDX_FC_EIP: v = {32'h0, s.fc_eip};
            MSRB_IDX_SIG:    v = {50'h0, s.sig};
            MSRB_IDX_VND1:   v = {32'h0, s.vnd1};
            MSRB_IDX_VND2:   v = {32'h0, s.vnd2};
            MSRB_IDX_VND3:   v = {32'h0, s.vnd3};
            MSRB_IDX_MASK:   v = {32'h0, s.mask};
            MSRB_IDX_PERF:   v = {s.perf_hi, s.perf_lo};
            default:         v = 64'h0000_0000_0000_0000;
        endcase
        read_value = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic        priv_ok;
        logic        bad;
        logic [63:0] wdata;
        logic [63:0] rdata;
        priv_ok    = 1'b0;
        bad        = 1'b0;
        wdata      = {req_in.edx, req_in.eax};
        rdata      = 64'h0000_0000_0000_0000;
        state_next = state_reg;
        state_next.rsp = '0;

        // Counter runs on the core clock, so it tracks any frequency change
        state_next.cycle_counter = state_reg.cycle_counter + 64'h0000_0000_0000_0001;

        // Strap caught once after release; reset itself loads only a constant
        if (!state_reg.strap_taken) begin
            state_next.strap_taken    = 1'b1;
            state_next.serial_disable = strap_sync_reg;
        end

        if (req_in.valid) begin
            state_next.rsp.done = 1'b1;
            priv_ok = (req_in.cpl == 2'b00);
            unique case (req_in.op)
                MSRB_OP_TSC: begin
                    if (req_in.tsd && !priv_ok) begin
                        state_next.rsp.fault = 1'b1;
                    end else begin
                        state_next.rsp.edx = state_reg.cycle_counter[63:32];
                        state_next.rsp.eax = state_reg.cycle_counter[31:0];
                    end
                end
                MSRB_OP_READ: begin
                    if (!priv_ok || !index_known(req_in.index)) begin
                        state_next.rsp.fault = 1'b1;
                    end else begin
                        rdata = read_value(state_reg, req_in.index);
                        state_next.rsp.edx = rdata[63:32];
                        state_next.rsp.eax = rdata[31:0];
                    end
                end
                MSRB_OP_WRITE: begin
                    bad = !priv_ok || !index_known(req_in.index);
                    bad = bad || ((wdata & reserved_bits(req_in.index)) != 64'h0);
                    if (req_in.index == MSRB_IDX_PERF) begin
                        bad = bad || (req_in.edx > MSRB_PERF_MAX) ||
                              (req_in.eax > MSRB_PERF_MAX) ||
                              (req_in.eax > req_in.edx);
                    end
                    state_next.rsp.fault     = bad;
                    state_next.rsp.serialize = !bad;
                    if (!bad) begin
                        unique case (req_in.index)
                            MSRB_IDX_CYCLE:  state_next.cycle_counter = wdata;
                            MSRB_IDX_SERIAL: state_next.serial_disable = state_reg.serial_disable |
                                                 wdata[MSRB_SERIAL_BIT];
                            MSRB_IDX_FC_SEL: state_next.fc_sel = wdata[31:0];
                            MSRB_IDX_FC_ESP: state_next.fc_esp = wdata[31:0];
                            MSRB_IDX_FC_EIP: state_next.fc_eip = wdata[31:0];
                            MSRB_IDX_SIG:    state_next.sig = wdata[13:0];
                            MSRB_IDX_VND1:   state_next.vnd1 = wdata[31:0];
                            MSRB_IDX_VND2:   state_next.vnd2 = wdata[31:0];
                            MSRB_IDX_VND3:   state_next.vnd3 = wdata[31:0];
                            MSRB_IDX_MASK:   state_next.mask = wdata[31:0];
                            MSRB_IDX_PERF: begin
                                state_next.perf_hi = wdata[63:32];
                                state_next.perf_lo = wdata[31:0];
                            end
                            default: state_next.mask = state_reg.mask;
                        endcase
                    end
                end
                default: state_next.rsp.fault = 1'b1;
            endcase
        end

        // Identification views come from the committed register values
        state_next.id.vendor_ebx    = state_next.vnd1;
        state_next.id.vendor_edx    = state_next.vnd2;
        state_next.id.vendor_ecx    = state_next.vnd3;
        state_next.id.signature_eax = {18'h0, state_next.sig};
        state_next.id.feature_edx   = (base_features_in |
            (32'h0000_0001 << MSRB_FC_FLAG_BIT)) & state_next.mask;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg                   <= '0;
            state_reg.sig               <= MSRB_SIG_RESET[13:0];
            state_reg.vnd1              <= MSRB_VND_RESET;
            state_reg.vnd2              <= MSRB_VND_RESET;
            state_reg.vnd3              <= MSRB_VND_RESET;
            state_reg.mask              <= MSRB_MASK_RESET;
            state_reg.perf_hi           <= MSRB_PERF_MAX;
            state_reg.perf_lo           <= MSRB_PERF_MAX;
            state_reg.id.feature_edx    <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rsp_out             = state_reg.rsp;
    assign id_out              = state_reg.id;
    assign serial_disabled_out = state_reg.serial_disable;
    assign cycle_count_out     = state_reg.cycle_counter;
endmodule

// File: msrb_bank_monitor.sv
`timescale 1ns/1ps
module msrb_bank_monitor (
    input  wire logic           clk_in,
    input  wire logic           resetn_in,
    input  wire logic [31:0]    base_features_in,
    input  msrb_pkg::msrb_req_s req_in,
    input  msrb_pkg::msrb_rsp_s rsp_out,
    input  msrb_pkg::msrb_id_s  id_out,
    input  wire logic           serial_disabled_out,
    input  wire logic [63:0]    cycle_count_out
);
    import msrb_pkg::*;
    logic known;
    logic rsv;
    assign known = req_in.index inside {MSRB_IDX_CYCLE, MSRB_IDX_SERIAL, MSRB_IDX_PERF,
        [MSRB_IDX_FC_SEL:MSRB_IDX_FC_EIP], [MSRB_IDX_SIG:MSRB_IDX_MASK]};
    assign rsv = ({req_in.edx, req_in.eax} & ~64'h0000000000200000) != 64'h0;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////////////////////////////
    AST_DONE: assert property (req_in.valid |=> rsp_out.done)
        else $error("request not answered");
    AST_PRIV: assert property (req_in.valid && req_in.op != MSRB_OP_TSC && req_in.cpl != 2'h0
        |=> rsp_out.fault) else $error("low privilege access not refused");
    AST_INDEX: assert property (req_in.valid && req_in.op != MSRB_OP_TSC && !known
        |=> rsp_out.fault) else $error("unknown index not refused");
    AST_RSVD: assert property (req_in.valid && req_in.op == MSRB_OP_WRITE && rsv
        && req_in.index == MSRB_IDX_SERIAL |=> rsp_out.fault && !rsp_out.serialize)
        else $error("reserved bit write not refused");
    AST_TSC: assert property (req_in.valid && req_in.op == MSRB_OP_TSC && !req_in.tsd
        |=> !rsp_out.fault) else $error("timestamp read refused");
    // All requests excluded since any write among them may target the counter
    AST_COUNT: assert property ($past(resetn_in) && !$past(req_in.valid)
        |-> cycle_count_out == $past(cycle_count_out) + 64'h1) else $error("counter step");
    AST_STICKY: assert property (serial_disabled_out |=> serial_disabled_out)
        else $error("serial disable bit cleared");
    AST_FEAT: assert property ((id_out.feature_edx & ~($past(base_features_in)
        | 32'h00000800)) == 32'h0) else $error("feature flag appeared");
    AST_FZERO: assert property (rsp_out.fault |-> rsp_out.done && rsp_out.edx == 32'h0
        && rsp_out.eax == 32'h0) else $error("faulted answer carries data");
    AST_SERIALIZE: assert property (req_in.valid && req_in.op == MSRB_OP_WRITE
        && req_in.cpl == 2'h0 && req_in.index == MSRB_IDX_FC_ESP |=> rsp_out.serialize)
        else $error("good write not serialized");
    AST_FC_UPPER: assert property (req_in.valid && req_in.op == MSRB_OP_READ
        && req_in.index inside {[MSRB_IDX_FC_SEL:MSRB_IDX_FC_EIP]} |=> rsp_out.edx == 32'h0)
        else $error("fast call upper half not zero");
endmodule
bind msrb_bank msrb_bank_monitor u_mon (.clk_in(clk_in), .resetn_in(resetn_in),
    .base_features_in(base_features_in), .req_in(req_in), .rsp_out(rsp_out), .id_out(id_out),
    .serial_disabled_out(serial_disabled_out), .cycle_count_out(cycle_count_out));

// File: msrb_core_model.sv
`timescale 1ns/1ps
module msrb_core_model (
    input  wire logic           clk_in,
    input  msrb_pkg::msrb_rsp_s rsp_in,
    output msrb_pkg::msrb_req_s req_out
);
    import msrb_pkg::*;
    initial req_out = '0;
    // Held falling edge to falling edge so the taking edge sees it steady
    task automatic issue(input logic [1:0] op, input logic [1:0] cpl, input logic tsd,
                         input logic [31:0] idx, input logic [63:0] d, output msrb_rsp_s r);
        @(negedge clk_in);
        req_out = '{1'b1, msrb_op_e'(op), cpl, tsd, idx, d[63:32], d[31:0]};
        @(posedge clk_in);
        @(negedge clk_in);
        r = rsp_in;
        // Inverse after release, so a stale field cannot pass for a live one
        req_out = '{1'b0, msrb_op_e'(~op), ~cpl, ~tsd, ~idx, ~d[63:32], ~d[31:0]};
    endtask
endmodule

// File: msrb_bank_bench.sv
`timescale 1ns/1ps
module msrb_bank_bench;
    import msrb_pkg::*;
    typedef struct packed {
        logic [1:0]  op;
        logic [31:0] idx;
        logic [63:0] d;
        logic        f;
        logic [63:0] q;
    } msrb_row_s;
    localparam int NROW = 23;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        strap = 1'b0;
    logic [31:0] base = 32'hFFFFF7FF;
    msrb_req_s   req;
    msrb_rsp_s   rsp;
    msrb_rsp_s   r;
    msrb_id_s    id;
    logic        sdis;
    logic [63:0] cnt;
    int          errors = 0;
    int          checked = 0;
    int          cyc = 0;
    msrb_row_s   rows [NROW] = '{
        '{2'h0, MSRB_IDX_MASK, 64'h0, 1'h0, 64'hFFFFFFFF},
        '{2'h0, MSRB_IDX_SERIAL, 64'h0, 1'h0, 64'h0},
        '{2'h1, MSRB_IDX_FC_SEL, 64'h12345678ABCDEF01, 1'h0, 64'h0},
        '{2'h0, MSRB_IDX_FC_SEL, 64'h0, 1'h0, 64'hABCDEF01},
        '{2'h1, MSRB_IDX_FC_EIP, 64'h12345678ABCDEF01, 1'h0, 64'h0},
        '{2'h0, MSRB_IDX_FC_EIP, 64'h0, 1'h0, 64'hABCDEF01},
        '{2'h1, MSRB_IDX_FC_ESP, 64'hFFFFFFFF13579BDF, 1'h0, 64'h0},
        '{2'h0, MSRB_IDX_FC_ESP, 64'h0, 1'h0, 64'h13579BDF},
        '{2'h1, MSRB_IDX_SIG, 64'h3FFF, 1'h0, 64'h0},
        '{2'h1, MSRB_IDX_SIG, 64'h4000, 1'h1, 64'h0},
        '{2'h1, MSRB_IDX_VND1, 64'hFFFFFFFF41424344, 1'h0, 64'h0},
        '{2'h1, MSRB_IDX_VND2, 64'hFFFFFFFF45464748, 1'h0, 64'h0},
        '{2'h0, MSRB_IDX_VND2, 64'h0, 1'h0, 64'h45464748},
        '{2'h1, MSRB_IDX_VND3, 64'h494A4B4C, 1'h0, 64'h0},
        '{2'h1, MSRB_IDX_MASK, 64'hFFFFFEFF, 1'h0, 64'h0},
        '{2'h1, MSRB_IDX_PERF, 64'h6400000010, 1'h0, 64'h0},
        '{2'h0, MSRB_IDX_PERF, 64'h0, 1'h0, 64'h6400000010},
        '{2'h1, MSRB_IDX_PERF, 64'h1000000020, 1'h1, 64'h0},
        '{2'h0, 32'h00000011, 64'h0, 1'h1, 64'h0},
        '{2'h1, MSRB_IDX_SERIAL, 64'h200000, 1'h0, 64'h0},
        '{2'h1, MSRB_IDX_SERIAL, 64'h0, 1'h0, 64'h0},
        '{2'h0, MSRB_IDX_SERIAL, 64'h0, 1'h0, 64'h200000},
        '{2'h1, MSRB_IDX_SERIAL, 64'h1, 1'h1, 64'h0}};
    msrb_bank u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .serial_disable_strap_in(strap),
        .base_features_in(base), .req_in(req), .rsp_out(rsp), .id_out(id),
        .serial_disabled_out(sdis), .cycle_count_out(cnt));
    msrb_core_model u_core (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
    always #2 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////
    task test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk_val(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // Generous ceiling; the whole run needs under two hundred cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            test_done;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < NROW; i++) begin
            u_core.issue(rows[i].op, 2'h0, 1'b0, rows[i].idx, rows[i].d, r);
            chk_bit(r.done, 1'b1);
            chk_bit(r.fault, rows[i].f);
            chk_bit(r.serialize, rows[i].op == 2'h1 && !rows[i].f);
            chk_val({r.edx, r.eax}, rows[i].q);
        end
        chk_val({id.vendor_ebx, id.signature_eax}, 64'h4142434400003FFF);
        chk_val({id.vendor_edx, id.vendor_ecx}, 64'h45464748494A4B4C);
        chk_val({32'h0, id.feature_edx}, 64'hFFFFFEFF);
        u_core.issue(2'h1, 2'h0, 1'b0, MSRB_IDX_CYCLE, 64'hFFFFFFFF, r);
        chk_val(cnt, 64'hFFFFFFFF);
        u_core.issue(2'h2, 2'h3, 1'b0, 32'h0, 64'h0, r);
        chk_bit(r.fault, 1'b0);
        chk_val({r.edx, r.eax}, 64'h100000000);
        u_core.issue(2'h2, 2'h3, 1'b1, 32'h0, 64'h0, r);
        chk_bit(r.fault, 1'b1);
        u_core.issue(2'h2, 2'h0, 1'b1, 32'h0, 64'h0, r);
        chk_bit(r.fault, 1'b0);
        u_core.issue(2'h0, 2'h3, 1'b0, MSRB_IDX_FC_SEL, 64'h0, r);
        chk_bit(r.fault, 1'b1);
        u_core.issue(2'h1, 2'h1, 1'b0, MSRB_IDX_FC_SEL, 64'h1, r);
        chk_bit(r.fault, 1'b1);
        chk_bit(r.serialize, 1'b0);
        u_core.issue(2'h0, 2'h0, 1'b0, MSRB_IDX_FC_SEL, 64'h0, r);
        chk_val({r.edx, r.eax}, 64'hABCDEF01);
        u_core.issue(2'h3, 2'h0, 1'b0, MSRB_IDX_MASK, 64'h0, r);
        chk_bit(r.fault, 1'b1);
        // Raw flags all clear, so only the forced fast call flag survives
        base = 32'h00000000;
        repeat (2) @(negedge clk_in);
        chk_val({32'h0, id.feature_edx}, 64'h800);
        // Strap changes well ahead of release, as the synchroniser needs
        strap = 1'b1;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (3) @(posedge clk_in);
        u_core.issue(2'h0, 2'h0, 1'b0, MSRB_IDX_SERIAL, 64'h0, r);
        chk_bit(sdis, 1'b1);
        chk_val({r.edx, r.eax}, 64'h200000);
        test_done;
    end
endmodule
